//--- rtl/erbf_block.sv
/*
 * Embedded RAM block: 9-kbit array with input registers, optional output
 * register, single/true dual/pseudo dual port RAM or FIFO operation.
 * Assumes user logic on the same clock drives every port; one clock serves
 * both ports and both FIFO sides.
 */
// Function
// - 9-kbit store with registered inputs and registered outputs.
// - Single, true dual, pseudo dual or FIFO; 8192x1 to 1024x9.
// - Pseudo dual port and FIFO also allow 512 words of 18 bits.
// - Each port has its own width; word count follows from width.
// - Word 0 sits in the lowest bits, LSB first, then word 1, per port.
// - Contents may be preloaded with initial data before use.
// - Preloaded with writes held off, the block behaves as a ROM.
// - Address and write data are registered at the array input.
// - Read data passes an output register only when that option is set.
// - FIFO drives full, almost full, empty and almost empty.
// - Read pointer clear rewinds reads without touching stored data.
// - True dual port has complete port sets A and B; pseudo dual writes on A, reads on B.
// - FIFO write and read sides have their own selects.
// - Full feedback blocks writes, empty feedback blocks reads.
// - Output read gate controls when FIFO read data is presented.
module erbf_block
  import erbf_pkg::*;
#(
  parameter erbf_mode_t MODE = ERBF_TRUE_DUAL,
  parameter int WIDTH_A = DEF_WIDTH,                      // 1, 2, 4, 9 or 18
  parameter int WIDTH_B = DEF_WIDTH,                      // 1, 2, 4, 9 or 18
  parameter bit OUT_REG = 1'b0,                           // Output register option
  parameter int ALMOST_FULL = DEF_ALMOST_FULL,
  parameter int ALMOST_EMPTY = DEF_ALMOST_EMPTY,
  parameter logic [STORE_BITS-1:0] INIT = '0              // Preload image
) (
  input wire logic clk,                                   // System clock
  input wire logic reset,                                 // Sync reset, loads image
  // Port A, also the FIFO write side
  input wire logic ce_a,                                  // Clock enable
  input wire logic cs_a,                                  // Chip select
  input wire logic we_a,                                  // Write enable
  input wire logic port_a_reset,                          // Clears A output regs
  input wire logic output_reg_enable_a,                   // Output register load
  input wire logic [MAX_LANES-1:0] byte_lane_enable_a,    // Lane write enables
  input wire logic [12:0] addr_a,                         // Word address
  input wire logic [WIDTH_A-1:0] din_a,                   // Write data
  output logic [WIDTH_A-1:0] dout_a,                      // Read data
  // Port B, also the FIFO read side
  input wire logic ce_b,                                  // Clock enable
  input wire logic cs_b,                                  // Chip select
  input wire logic we_b,                                  // Write enable
  input wire logic port_b_reset,                          // Clears B output regs
  input wire logic output_reg_enable_b,                   // Output register load
  input wire logic [MAX_LANES-1:0] byte_lane_enable_b,    // Lane write enables
  input wire logic [12:0] addr_b,                         // Word address
  input wire logic [WIDTH_B-1:0] din_b,                   // Write data
  output logic [WIDTH_B-1:0] dout_b,                      // Read data
  // FIFO controls and flags
  input wire logic write_side_select,                     // Write side select
  input wire logic full_feedback_in,                      // Second write select, low active
  input wire logic read_side_select,                      // Read side select
  input wire logic empty_feedback_in,                     // Second read select, low active
  input wire logic output_read_gate,                      // Presents read data
  input wire logic read_pointer_clear,                    // Rewinds read pointer
  output logic full_flag,                                 // Write staging full
  output logic almost_full_flag,                          // Array at upper level
  output logic empty_flag,                                // Array holds no word
  output logic almost_empty_flag                          // Array at lower level
);

  // ****************************************************************
  // Geometry per port
  // ****************************************************************
  localparam int BITS_A = (WIDTH_A % LANE_BITS == 0) ? STORE_BITS : PLAIN_BITS;
  localparam int BITS_B = (WIDTH_B % LANE_BITS == 0) ? STORE_BITS : PLAIN_BITS;
  localparam int DEPTH_A = BITS_A / WIDTH_A;
  localparam int DEPTH_B = BITS_B / WIDTH_B;
  localparam int AW_A = $clog2(DEPTH_A);
  localparam int AW_B = $clog2(DEPTH_B);
  localparam int LANES_A = (WIDTH_A > LANE_BITS) ? MAX_LANES : 1;
  localparam int LANES_B = (WIDTH_B > LANE_BITS) ? MAX_LANES : 1;
  localparam int LW_A = WIDTH_A / LANES_A;
  localparam int LW_B = WIDTH_B / LANES_B;
  localparam logic [AW_B:0] FULL_WORDS = (AW_B + 1)'(DEPTH_B);
  localparam logic [AW_B:0] AF_LEVEL = (AW_B + 1)'(ALMOST_FULL);
  localparam logic [AW_B:0] AE_LEVEL = (AW_B + 1)'(ALMOST_EMPTY);
  localparam bit IS_FIFO = (MODE == ERBF_FIFO);
  localparam bit A_WRITES = (MODE != ERBF_FIFO);
  localparam bit A_READS = (MODE == ERBF_SINGLE) || (MODE == ERBF_TRUE_DUAL);
  localparam bit B_USED = (MODE != ERBF_SINGLE);
  localparam bit B_WRITES = (MODE == ERBF_TRUE_DUAL);

  // ****************************************************************
  // State of the block
  // ****************************************************************
  typedef struct packed {
    logic [STORE_BITS-1:0] mem;
    logic [AW_A-1:0] reg_addr_a;
    logic [WIDTH_A-1:0] reg_data_a;
    logic [LANES_A-1:0] reg_lanes_a;
    logic reg_wr_a;
    logic reg_rd_a;
    logic [AW_B-1:0] reg_addr_b;
    logic [WIDTH_B-1:0] reg_data_b;
    logic [LANES_B-1:0] reg_lanes_b;
    logic reg_wr_b;
    logic reg_rd_b;
    logic [WIDTH_A-1:0] pipe_a;
    logic [WIDTH_A-1:0] out_a;
    logic [WIDTH_B-1:0] pipe_b;
    logic [WIDTH_B-1:0] out_b;
    logic [AW_B:0] wptr;
    logic [AW_B:0] rptr;
    logic empty;
    logic almost_full;
    logic almost_empty;
  } erbf_state_t;

  erbf_state_t state;
  erbf_state_t next_state;

  // Staging buffer streams on the FIFO write side
  erbf_stream_if #(.WIDTH(WIDTH_A)) stage_in ();
  erbf_stream_if #(.WIDTH(WIDTH_A)) stage_out ();

  logic [AW_B:0] fifo_words;
  logic [AW_B:0] next_words;
  logic fifo_push;
  logic fifo_drain;
  logic fifo_pop;
  logic [WIDTH_A-1:0] array_a;
  logic [WIDTH_B-1:0] array_b;
  logic load_a;
  logic load_b;

  // ****************************************************************
  // FIFO side handshakes
  // ****************************************************************
  // Writes are refused by the staging buffer's full, never dropped silently
  assign fifo_words = state.wptr - state.rptr;
  assign fifo_push = IS_FIFO & ce_a & write_side_select & ~full_feedback_in & we_a;
  assign stage_in.valid = fifo_push;
  assign stage_in.data = din_a;
  // Drain only while the array has room, which lets the staging buffer fill
  assign fifo_drain = IS_FIFO & stage_out.valid & (fifo_words != FULL_WORDS);
  assign stage_out.ready = fifo_drain;
  assign stage_out.full = 1'b0;
  assign fifo_pop = IS_FIFO & ce_b & read_side_select & ~empty_feedback_in
                  & (fifo_words != '0);

  erbf_stage_fifo #(
    .WIDTH(WIDTH_A),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .clk(clk),
    .reset(reset),
    .fill(stage_in),
    .drain(stage_out)
  );

  // ****************************************************************
  // Array read paths from the registered addresses
  // ****************************************************************
  // Linear mapping: word k of a port lies at bits k*width upward
  assign array_a = state.mem[int'(state.reg_addr_a) * WIDTH_A +: WIDTH_A];
  assign array_b = state.mem[int'(state.reg_addr_b) * WIDTH_B +: WIDTH_B];
  // The read gate stands in for the output load enable on the FIFO read side
  assign load_a = output_reg_enable_a;
  assign load_b = IS_FIFO ? output_read_gate : output_reg_enable_b;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_words = '0;
    // Array stage: writes land one edge after capture
    if (state.reg_wr_a) begin
      for (int l = 0; l < LANES_A; l++) begin
        if (state.reg_lanes_a[l]) begin
          next_state.mem[int'(state.reg_addr_a) * WIDTH_A + l * LW_A +: LW_A] =
            state.reg_data_a[l * LW_A +: LW_A];
        end
      end
    end
    // Port B writes after A, so B wins an equal-address collision
    if (state.reg_wr_b) begin
      for (int l = 0; l < LANES_B; l++) begin
        if (state.reg_lanes_b[l]) begin
          next_state.mem[int'(state.reg_addr_b) * WIDTH_B + l * LW_B +: LW_B] =
            state.reg_data_b[l * LW_B +: LW_B];
        end
      end
    end

    // Input registers of port A, or the drained staging word in FIFO mode
    next_state.reg_wr_a = 1'b0;
    next_state.reg_rd_a = 1'b0;
    if (IS_FIFO) begin
      if (fifo_drain) begin
        next_state.reg_addr_a = state.wptr[AW_B-1:0];
        next_state.reg_data_a = stage_out.data;
        next_state.reg_lanes_a = '1;
        next_state.reg_wr_a = 1'b1;
        next_state.wptr = state.wptr + (AW_B + 1)'(1);
      end
    end else if (ce_a && cs_a) begin
      next_state.reg_addr_a = addr_a[AW_A-1:0];
      next_state.reg_data_a = din_a;
      next_state.reg_lanes_a = byte_lane_enable_a[LANES_A-1:0];
      next_state.reg_wr_a = A_WRITES & we_a;
      next_state.reg_rd_a = A_READS & ~we_a;
    end

    // Input registers of port B, or the read pointer in FIFO mode
    next_state.reg_wr_b = 1'b0;
    next_state.reg_rd_b = 1'b0;
    if (IS_FIFO) begin
      if (read_pointer_clear) begin
        next_state.rptr = '0;
      end else if (fifo_pop) begin
        next_state.reg_addr_b = state.rptr[AW_B-1:0];
        next_state.reg_rd_b = 1'b1;
        next_state.rptr = state.rptr + (AW_B + 1)'(1);
      end
    end else if (B_USED && ce_b && cs_b) begin
      next_state.reg_addr_b = addr_b[AW_B-1:0];
      next_state.reg_data_b = din_b;
      next_state.reg_lanes_b = byte_lane_enable_b[LANES_B-1:0];
      next_state.reg_wr_b = B_WRITES & we_b;
      next_state.reg_rd_b = ~(B_WRITES & we_b);
    end

    // Output path of port A
    if (port_a_reset) begin
      next_state.pipe_a = '0;
      next_state.out_a = '0;
    end else if (OUT_REG) begin
      if (state.reg_rd_a) begin
        next_state.pipe_a = array_a;
      end
      if (load_a) begin
        next_state.out_a = state.pipe_a;
      end
    end else if (state.reg_rd_a) begin
      next_state.out_a = array_a;
    end

    // Output path of port B
    if (port_b_reset) begin
      next_state.pipe_b = '0;
      next_state.out_b = '0;
    end else if (OUT_REG) begin
      if (state.reg_rd_b) begin
        next_state.pipe_b = array_b;
      end
      if (load_b) begin
        next_state.out_b = state.pipe_b;
      end
    end else if (state.reg_rd_b && (!IS_FIFO || load_b)) begin
      next_state.out_b = array_b;
    end

    // FIFO level flags from the next pointers, so they are exact when seen
    next_words = next_state.wptr - next_state.rptr;
    next_state.empty = IS_FIFO & (next_words == '0);
    next_state.almost_full = IS_FIFO & (next_words >= AF_LEVEL);
    next_state.almost_empty = IS_FIFO & (next_words <= AE_LEVEL);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset stands in for configuration: it loads the preload image
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
      state.mem <= INIT;
      state.empty <= IS_FIFO;
      state.almost_empty <= IS_FIFO;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign dout_a = state.out_a;
  assign dout_b = state.out_b;
  assign full_flag = IS_FIFO & stage_in.full;
  assign almost_full_flag = state.almost_full;
  assign empty_flag = state.empty;
  assign almost_empty_flag = state.almost_empty;

endmodule : erbf_block

//--- rtl/erbf_pkg.sv
/*
 * Shared constants and types of the embedded RAM block with FIFO mode.
 * Assumes one system clock and a synchronous active-high reset everywhere.
 */
package erbf_pkg;

  // ****************************************************************
  // Storage geometry
  // ****************************************************************
  localparam int STORE_BITS = 9216;     // Full array, used by 9 and 18 bit shapes
  localparam int PLAIN_BITS = 8192;     // Usable bits for 1, 2 and 4 bit shapes
  localparam int LANE_BITS = 9;         // One byte lane including its ninth bit
  localparam int MAX_LANES = 2;         // Byte lanes of the widest (18 bit) word
  localparam int DEF_WIDTH = 9;         // Default port width
  localparam int STAGE_DEPTH = 32;      // Words of the FIFO write staging buffer

  // ****************************************************************
  // FIFO flag defaults, in words held by the array
  // ****************************************************************
  localparam int DEF_ALMOST_FULL = 1000;
  localparam int DEF_ALMOST_EMPTY = 8;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef enum logic [1:0] {
    ERBF_SINGLE,
    ERBF_TRUE_DUAL,
    ERBF_PSEUDO_DUAL,
    ERBF_FIFO
  } erbf_mode_t;

endpackage : erbf_pkg

//--- rtl/erbf_stream_if.sv
/*
 * Valid/ready word stream between the block and its staging buffer.
 * Assumes both ends run on the same clock.
 */
interface erbf_stream_if #(
  parameter int WIDTH = 9
);
  logic valid;
  logic ready;
  logic full;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready, input full);
  modport dst (input valid, input data, output ready, output full);
endinterface : erbf_stream_if

//--- rtl/erbf_stage_fifo.sv
/*
 * Small synchronous FIFO built from flip-flops, valid/ready on both sides.
 * Assumes one clock; the drain side may stall so the buffer really fills.
 */
module erbf_stage_fifo
  import erbf_pkg::*;
#(
  parameter int WIDTH = DEF_WIDTH,
  parameter int DEPTH = STAGE_DEPTH
) (
  input wire logic clk,       // System clock
  input wire logic reset,     // Synchronous reset, active high
  erbf_stream_if.dst fill,    // Filling side
  erbf_stream_if.src drain    // Draining side
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] count;
    logic full;
  } erbf_stage_t;

  erbf_stage_t state;
  erbf_stage_t next_state;
  logic do_push;
  logic do_pop;

  // ****************************************************************
  // Handshakes; ready and full are derived from the registered count
  // ****************************************************************
  assign fill.ready = ~state.full;
  assign fill.full = state.full;
  assign drain.valid = (state.count != '0);
  assign drain.data = state.mem[state.rp];
  assign do_push = fill.valid & fill.ready;
  assign do_pop = drain.valid & drain.ready;

  // Next state: write at wp, read at rp, count tracks both
  always_comb begin
    next_state = state;
    if (do_push) begin
      next_state.mem[state.wp] = fill.data;
      next_state.wp = state.wp + PW'(1);
    end
    if (do_pop) begin
      next_state.rp = state.rp + PW'(1);
    end
    next_state.count = state.count + (PW + 1)'(do_push) - (PW + 1)'(do_pop);
    next_state.full = (next_state.count == (PW + 1)'(DEPTH));
  end

  // Storage is not cleared on reset, only the pointers, count and full flag
  always_ff @(posedge clk) begin
    if (reset) begin
      state.mem <= state.mem;
      state.wp <= '0;
      state.rp <= '0;
      state.count <= '0;
      state.full <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

endmodule : erbf_stage_fifo

//--- tb/erbf_block_chk.sv
/*
 * Checker for the block in FIFO mode: read side output and the four flags.
 * Assumes one clock, bound to erbf_block from the bench top.
 */
module erbf_block_chk
  import erbf_pkg::*;
#(
  parameter int WIDTH_B = DEF_WIDTH
) (
  input wire logic clk,                    // System clock
  input wire logic reset,                  // Sync reset
  input wire logic ce_b,                   // Read side enable
  input wire logic read_side_select,       // Read side select
  input wire logic empty_feedback_in,      // Read blocker
  input wire logic output_read_gate,       // Read data gate
  input wire logic port_b_reset,           // Output clear
  input wire logic [WIDTH_B-1:0] dout_b,   // Read data
  input wire logic full_flag,              // Staging full
  input wire logic almost_full_flag,       // Upper level
  input wire logic empty_flag,             // No word held
  input wire logic almost_empty_flag       // Lower level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pop_req;

  // ****************************************************************
  // Read request decode
  // ****************************************************************
  assign pop_req = ce_b && read_side_select;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Output only moves one edge after a pop, or on a port reset
  a_port_reset_clears: assert property (port_b_reset |=> dout_b == '0)
    else $error("dout_b not cleared by port reset");
  a_release_state: assert property ($fell(reset) |->
    empty_flag && almost_empty_flag && !almost_full_flag && !full_flag)
    else $error("flags wrong after reset");
  a_idle_holds: assert property (!pop_req ##1 !port_b_reset |=> $stable(dout_b))
    else $error("dout_b moved without a pop");
  a_feedback_blocks: assert property (
    pop_req && empty_feedback_in ##1 !port_b_reset |=> $stable(dout_b))
    else $error("dout_b moved on a blocked pop");
  a_gate_hides_word: assert property (
    pop_req ##1 (!output_read_gate && !port_b_reset) |=> $stable(dout_b))
    else $error("dout_b moved with read gate low");
  a_empty_pop_ignored: assert property (
    pop_req && empty_flag ##1 !port_b_reset |=> $stable(dout_b))
    else $error("dout_b moved on pop while empty");
  a_full_has_afull: assert property (full_flag |-> almost_full_flag)
    else $error("full without almost full");
  a_empty_has_aempty: assert property (
    empty_flag |-> almost_empty_flag && !almost_full_flag)
    else $error("empty flag disagrees with level flags");
endmodule : erbf_block_chk

//--- tb/erbf_user_model.sv
/*
 * User logic model driving every control input of the block except reset.
 * Assumes the bench calls step once per cycle; values change at rising edges.
 */
module erbf_user_model (
  input wire logic clk,                    // System clock
  output logic ce_a,                       // Write side enable
  output logic cs_a,                       // Port A select
  output logic we_a,                       // Write enable
  output logic port_a_reset,               // A output clear
  output logic output_reg_enable_a,        // A output load
  output logic [1:0] byte_lane_enable_a,   // A lanes
  output logic [12:0] addr_a,              // A address
  output logic [8:0] din_a,                // Pushed word
  output logic ce_b,                       // Read side enable
  output logic cs_b,                       // Port B select
  output logic we_b,                       // B write enable
  output logic port_b_reset,               // B output clear
  output logic output_reg_enable_b,        // B output load
  output logic [1:0] byte_lane_enable_b,   // B lanes
  output logic [12:0] addr_b,              // B address
  output logic [8:0] din_b,                // B data
  output logic write_side_select,          // Push select
  output logic full_feedback_in,           // Push blocker
  output logic read_side_select,           // Pop select
  output logic empty_feedback_in,          // Pop blocker
  output logic output_read_gate,           // Read gate
  output logic read_pointer_clear          // Rewind
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet state at time zero
  initial begin
    {ce_a, cs_a, we_a, port_a_reset, output_reg_enable_a, ce_b, cs_b, we_b} = 8'h00;
    {port_b_reset, output_reg_enable_b, write_side_select, full_feedback_in} = 4'h0;
    {read_side_select, empty_feedback_in, output_read_gate, read_pointer_clear} = 4'h0;
    {byte_lane_enable_a, byte_lane_enable_b, addr_a, addr_b} = 30'h0;
    {din_a, din_b} = 18'h0;
  end

  // One cycle of requests: 0 idle, 1 push, 2 blocked push, 3 pop,
  // 4 blocked pop, 5 rewind, 6 output clear. Unused address and data
  // lines toggle so that nothing can lean on a held value.
  task automatic step(input int op, input logic [8:0] d, input logic g);
    @(posedge clk);
    ce_a <= op inside {1, 2};
    cs_a <= op inside {1, 2};
    we_a <= op inside {1, 2};
    write_side_select <= op inside {1, 2};
    byte_lane_enable_a <= {2{op == 1}};
    full_feedback_in <= (op == 2);
    din_a <= (op inside {1, 2}) ? d : ~din_a;
    ce_b <= op inside {3, 4};
    cs_b <= op inside {3, 4};
    read_side_select <= op inside {3, 4};
    empty_feedback_in <= (op == 4);
    read_pointer_clear <= (op == 5);
    port_a_reset <= (op == 6);
    port_b_reset <= (op == 6);
    output_read_gate <= g;
    output_reg_enable_a <= g;
    output_reg_enable_b <= g;
    addr_a <= ~addr_a;
    addr_b <= ~addr_b;
    din_b <= ~din_b;
  endtask : step
endmodule : erbf_user_model

//--- tb/tb_top.sv
/*
 * Bench top: block in FIFO mode, 9-bit words, no output register.
 * Assumes the user model, the checker and the design files are compiled first.
 */
module tb_top
  import erbf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FILL = 1024 + STAGE_DEPTH; // Array words plus staging words
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce_a, cs_a, we_a, port_a_reset, output_reg_enable_a, ce_b, cs_b, we_b;
  logic port_b_reset, output_reg_enable_b, write_side_select, full_feedback_in;
  logic read_side_select, empty_feedback_in, output_read_gate, read_pointer_clear;
  logic full_flag, almost_full_flag, empty_flag, almost_empty_flag;
  logic [1:0] byte_lane_enable_a, byte_lane_enable_b;
  logic [12:0] addr_a, addr_b;
  logic [8:0] din_a, din_b, dout_a, dout_b;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  erbf_block #(.MODE(ERBF_FIFO), .WIDTH_A(9), .WIDTH_B(9), .OUT_REG(1'b0)) erbf_block_inst (
    .clk(clk), .reset(reset), .ce_a(ce_a), .cs_a(cs_a), .we_a(we_a),
    .port_a_reset(port_a_reset), .output_reg_enable_a(output_reg_enable_a),
    .byte_lane_enable_a(byte_lane_enable_a), .addr_a(addr_a), .din_a(din_a),
    .dout_a(dout_a), .ce_b(ce_b), .cs_b(cs_b), .we_b(we_b), .port_b_reset(port_b_reset),
    .output_reg_enable_b(output_reg_enable_b), .byte_lane_enable_b(byte_lane_enable_b),
    .addr_b(addr_b), .din_b(din_b), .dout_b(dout_b), .write_side_select(write_side_select),
    .full_feedback_in(full_feedback_in), .read_side_select(read_side_select),
    .empty_feedback_in(empty_feedback_in), .output_read_gate(output_read_gate),
    .read_pointer_clear(read_pointer_clear), .full_flag(full_flag),
    .almost_full_flag(almost_full_flag), .empty_flag(empty_flag),
    .almost_empty_flag(almost_empty_flag));

  erbf_user_model erbf_user_model_inst (
    .clk(clk), .ce_a(ce_a), .cs_a(cs_a), .we_a(we_a), .port_a_reset(port_a_reset),
    .output_reg_enable_a(output_reg_enable_a), .byte_lane_enable_a(byte_lane_enable_a),
    .addr_a(addr_a), .din_a(din_a), .ce_b(ce_b), .cs_b(cs_b), .we_b(we_b),
    .port_b_reset(port_b_reset), .output_reg_enable_b(output_reg_enable_b),
    .byte_lane_enable_b(byte_lane_enable_b), .addr_b(addr_b), .din_b(din_b),
    .write_side_select(write_side_select), .full_feedback_in(full_feedback_in),
    .read_side_select(read_side_select), .empty_feedback_in(empty_feedback_in),
    .output_read_gate(output_read_gate), .read_pointer_clear(read_pointer_clear));

  // ****************************************************************
  // Compare, stimulus and closing tasks
  // ****************************************************************
  task automatic chk_word(input string what, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  task automatic go(input int op, input logic [8:0] d, input logic g);
    erbf_user_model_inst.step(op, d, g);
  endtask : go

  // Request, then wait for the pipe and the gated output load
  task automatic pop_check(input int op, input logic g, input logic [8:0] exp, input string s);
    go(op, 9'h000, g);
    go(0, 9'h000, g);
    go(0, 9'h000, g);
    #1;
    chk_word(s, exp, dout_b);
  endtask : pop_check

  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // Hang guard, well above the roughly 2200 cycles of the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      summarize();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk_flag("empty_flag", 1'b1, empty_flag);
    chk_flag("almost_empty_flag", 1'b1, almost_empty_flag);
    chk_flag("almost_full_flag", 1'b0, almost_full_flag);
    chk_flag("full_flag", 1'b0, full_flag);
    chk_word("dout_b after reset", 9'h000, dout_b);
    pop_check(3, 1'b1, 9'h000, "pop while empty");
    for (int i = 0; i < 4; i++) begin
      go(1, 9'h0A0 + 9'(i), 1'b1);
    end
    go(2, 9'h1FF, 1'b1);
    repeat (3) go(0, 9'h000, 1'b1);
    #1;
    chk_flag("empty_flag", 1'b0, empty_flag);
    chk_flag("almost_empty_flag", 1'b1, almost_empty_flag);
    pop_check(3, 1'b1, 9'h0A0, "first pop");
    pop_check(3, 1'b0, 9'h0A0, "gated pop");
    pop_check(4, 1'b1, 9'h0A0, "blocked pop");
    go(5, 9'h000, 1'b1);
    for (int i = 0; i < 4; i++) begin
      pop_check(3, 1'b1, 9'h0A0 + 9'(i), "rewound pop");
    end
    // The blocked push must not have stored its word
    pop_check(3, 1'b1, 9'h0A3, "pop past end");
    chk_flag("empty_flag", 1'b1, empty_flag);
    pop_check(6, 1'b1, 9'h000, "port reset");
    // Fill with the reader stalled, past the point of refusal
    for (int i = 0; i < FILL + 40; i++) begin
      go(1, 9'(i), 1'b1);
    end
    repeat (3) go(0, 9'h000, 1'b1);
    #1;
    chk_flag("full_flag", 1'b1, full_flag);
    chk_flag("almost_full_flag", 1'b1, almost_full_flag);
    // Back-to-back pops: each word shows two edges after its request
    for (int j = 0; j < FILL + 2; j++) begin
      go((j < FILL) ? 3 : 0, 9'h000, 1'b1);
      #1;
      if (j >= 2) begin
        chk_word("drained word", 9'(j - 2), dout_b);
      end
      if (j == 600) begin
        chk_flag("almost_full_flag", 1'b0, almost_full_flag);
        chk_flag("almost_empty_flag", 1'b0, almost_empty_flag);
      end
    end
    chk_flag("empty_flag", 1'b1, empty_flag);
    chk_flag("full_flag", 1'b0, full_flag);
    chk_word("dout_a", 9'h000, dout_a);
    summarize();
  end
endmodule : tb_top

bind erbf_block erbf_block_chk #(.WIDTH_B(WIDTH_B)) erbf_block_chk_inst (
  .clk(clk), .reset(reset), .ce_b(ce_b), .read_side_select(read_side_select),
  .empty_feedback_in(empty_feedback_in), .output_read_gate(output_read_gate),
  .port_b_reset(port_b_reset), .dout_b(dout_b), .full_flag(full_flag),
  .almost_full_flag(almost_full_flag), .empty_flag(empty_flag),
  .almost_empty_flag(almost_empty_flag));
